//--- rtl/serializer_link_gpio.sv
/*
  Four-pin general-purpose block of a link serializer: local register control,
  forwarding of pin levels into forward frames, remote pin values from back frames.
  Assumes the link logic marks each forward frame by a LINK_CLK rising edge and each
  back frame by a toggle of BC_FRAME_TGL; both arrive from outside the clock domain.
*/
`timescale 1ns/100ps
module serializer_link_gpio #(
  parameter int NPINS = 4
) (
  // Clock, reset, enable
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET_N,
  input  wire logic                     CE,
  // Register port
  input  wire link_pin_pkg::reg_req_s   REG_REQ,
  output      logic [7:0]               REG_RDATA,
  output      logic                     REG_ACK,
  // Pins
  input  wire logic [NPINS-1:0]         PIN_IN,
  output      logic [NPINS-1:0]         PIN_OUT,
  output      logic [NPINS-1:0]         PIN_OE,
  output      logic [NPINS-1:0]         PIN_PULLDOWN,
  output      logic [1:0]               VSENSE_EN,
  // Forward channel
  input  wire logic                     LINK_CLK,
  output      link_pin_pkg::fwd_sample_s FWD_SAMPLE,
  output      logic                     FWD_STB,
  // Back channel
  input  wire logic [NPINS-1:0]         BC_PIN_VAL,
  input  wire logic                     BC_FRAME_TGL
);
  logic [7:0]       remote_sel_r;
  logic [7:0]       dir_ctrl_r;
  logic [7:0]       fwd_cfg_r;
  logic [NPINS-1:0] pin_s1_r;
  logic [NPINS-1:0] pin_s2_r;
  logic [2:0]       link_s_r;
  logic [NPINS-1:0] bcv_s1_r;
  logic [NPINS-1:0] bcv_s2_r;
  logic [2:0]       bct_s_r;
  logic [2:0]       sync_fill_r;
  logic [NPINS-1:0] remote_val_r;
  logic [2:0]       frame_cnt_r;
  logic [2:0]       frame_cnt_nxt;
  logic [2:0]       period;
  logic [2:0]       fwd_count;
  logic [NPINS-1:0] fwd_mask;
  logic [NPINS-1:0] in_en;
  logic [NPINS-1:0] drv_en;
  logic [NPINS-1:0] remote_en;
  logic [NPINS-1:0] local_val;
  logic [NPINS-1:0] level_bits;
  logic             link_rise;
  logic             bc_frame;

  assign in_en     = dir_ctrl_r[link_pin_pkg::IN_EN_LSB +: NPINS];
  assign drv_en    = dir_ctrl_r[link_pin_pkg::DRV_EN_LSB +: NPINS];
  assign remote_en = remote_sel_r[link_pin_pkg::REMOTE_EN_LSB +: NPINS];
  assign local_val = remote_sel_r[link_pin_pkg::LOCAL_LSB +: NPINS];
  assign fwd_count = fwd_cfg_r[link_pin_pkg::CNT_LSB +: 3];

  // Register writes
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      remote_sel_r <= link_pin_pkg::RST_REMOTE_SEL;
      dir_ctrl_r   <= link_pin_pkg::RST_DIR_CTRL;
      fwd_cfg_r    <= link_pin_pkg::RST_FWD_CFG;
    end else if (CE && REG_REQ.wr) begin
      case (REG_REQ.addr)
        link_pin_pkg::OFS_REMOTE_SEL: remote_sel_r <= REG_REQ.wdata;
        link_pin_pkg::OFS_DIR_CTRL:   dir_ctrl_r   <= REG_REQ.wdata;
        link_pin_pkg::OFS_FWD_CFG:    fwd_cfg_r    <= REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  // Status shows level only where input is enabled; an output-only pin reads 0
  assign level_bits = pin_s2_r & in_en;

  // Register reads, one-cycle acknowledge; unmapped reads return zero
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
      REG_ACK   <= 1'b0;
    end else if (CE) begin
      REG_ACK <= REG_REQ.wr | REG_REQ.rd;
      if (REG_REQ.rd) begin
        case (REG_REQ.addr)
          link_pin_pkg::OFS_REMOTE_SEL: REG_RDATA <= remote_sel_r;
          link_pin_pkg::OFS_DIR_CTRL:   REG_RDATA <= dir_ctrl_r;
          link_pin_pkg::OFS_FWD_CFG:    REG_RDATA <= fwd_cfg_r;
          link_pin_pkg::OFS_LEVEL_STS:  REG_RDATA <= {{(8-NPINS){1'b0}}, level_bits};
          default:                      REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  // Synchronisers; first stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      link_s_r <= 3'h0;
      bcv_s1_r <= '0;
      bcv_s2_r <= '0;
      bct_s_r  <= 3'h0;
      sync_fill_r <= 3'h0;
    end else if (CE) begin
      pin_s1_r <= PIN_IN;
      pin_s2_r <= pin_s1_r;
      link_s_r <= {link_s_r[1:0], LINK_CLK};
      bcv_s1_r <= BC_PIN_VAL;
      bcv_s2_r <= bcv_s1_r;
      bct_s_r  <= {bct_s_r[1:0], BC_FRAME_TGL};
      sync_fill_r <= {sync_fill_r[1:0], 1'b1};
    end
  end

  // Edges held off until the last stage holds a real sample, so that
  // a toggle left high across reset does not fake a frame
  assign link_rise = link_s_r[1] & ~link_s_r[2] & sync_fill_r[2];
  assign bc_frame  = (bct_s_r[1] ^ bct_s_r[2]) & sync_fill_r[2];

  // Sampling period from the linked pin count
  always_comb begin
    case (fwd_count)
      3'h1:    period = link_pin_pkg::PERIOD_ONE;
      3'h2:    period = link_pin_pkg::PERIOD_TWO;
      3'h3,
      3'h4:    period = link_pin_pkg::PERIOD_MANY;
      default: period = 3'h0;
    endcase
  end

  always_comb begin
    fwd_mask = '0;
    for (int i = 0; i < NPINS; i++) begin
      fwd_mask[i] = (3'(i) < fwd_count);
    end
  end

  always_comb begin
    frame_cnt_nxt = frame_cnt_r;
    if (period == 3'h0) begin
      frame_cnt_nxt = 3'h0;
    end else if (REG_REQ.wr && REG_REQ.addr == link_pin_pkg::OFS_FWD_CFG) begin
      // New count restarts the cadence; a stale phase would skip frames
      frame_cnt_nxt = 3'h0;
    end else if (link_rise) begin
      frame_cnt_nxt = (frame_cnt_r + 3'h1 >= period) ? 3'h0 : frame_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      frame_cnt_r <= 3'h0;
    end else if (CE) begin
      frame_cnt_r <= frame_cnt_nxt;
    end
  end

  // Forward sample, one per sampling period, at the frame that opens it
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      FWD_SAMPLE <= '0;
      FWD_STB    <= 1'b0;
    end else if (CE) begin
      FWD_STB <= link_rise && period != 3'h0 && frame_cnt_r == 3'h0;
      if (link_rise && period != 3'h0 && frame_cnt_r == 3'h0) begin
        FWD_SAMPLE.pins  <= pin_s2_r & fwd_mask;
        FWD_SAMPLE.count <= fwd_count;
      end
    end
  end

  // Remote values caught once per back frame; the back frame rate sets the sampling rate
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      remote_val_r <= '0;
    end else if (CE && bc_frame) begin
      remote_val_r <= bcv_s2_r;
    end
  end

  // Pin drive: remote value (frame sync too) or local data
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      PIN_OUT      <= '0;
      PIN_OE       <= '0;
      PIN_PULLDOWN <= '0;
      VSENSE_EN    <= 2'h0;
    end else if (CE) begin
      PIN_OUT      <= (remote_en & remote_val_r) | (~remote_en & local_val);
      PIN_OE       <= drv_en;
      PIN_PULLDOWN <= in_en;
      VSENSE_EN    <= fwd_cfg_r[link_pin_pkg::SENSE_LSB +: 2];
    end
  end

  // Checks
  sequence s_bc_toggle;
    CE && bc_frame;
  endsequence

  sequence s_pin_follows;
    ##[1:2] (PIN_OUT[0] == (remote_en[0] ? remote_val_r[0] : local_val[0]));
  endsequence

  property p_reset_inputs;
    @(posedge CLK_SYS) $rose(RESET_N) |-> (in_en == {NPINS{1'b1}}) && (drv_en == '0);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

  property p_status_gated;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && REG_REQ.rd && REG_REQ.addr == link_pin_pkg::OFS_LEVEL_STS |=>
      REG_RDATA[NPINS-1:0] == ($past(pin_s2_r) & $past(in_en)) && REG_ACK;
  endproperty
  a_status_gated: assert property (p_status_gated) else $error("status read wrong");

  property p_outonly_zero;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && REG_REQ.rd && REG_REQ.addr == link_pin_pkg::OFS_LEVEL_STS && !in_en[0] |=>
      !REG_RDATA[0];
  endproperty
  a_outonly_zero: assert property (p_outonly_zero) else $error("output-only status set");

  property p_oe_follows;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE |=> PIN_OE == $past(drv_en);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("drive enable not applied");

  property p_pulldown;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && in_en[1] ##1 CE |-> PIN_PULLDOWN[1];
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down missing");

  property p_one_every_frame;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && fwd_count == 3'h1 && link_rise |=> FWD_STB;
  endproperty
  a_one_every_frame: assert property (p_one_every_frame) else $error("single pin not sent");

  property p_many_period;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && fwd_count == 3'h4 && frame_cnt_r != 3'h0 |=> !FWD_STB;
  endproperty
  a_many_period: assert property (p_many_period) else $error("four pins sent off period");

  property p_fwd_latency;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      FWD_STB |-> FWD_SAMPLE.pins == ($past(pin_s2_r) & $past(fwd_mask)) &&
      $past(link_rise, 1);
  endproperty
  a_fwd_latency: assert property (p_fwd_latency) else $error("forward sample stale");

  property p_remote_skew;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      s_bc_toggle ##1 CE [*2] |-> s_pin_follows;
  endproperty
  a_remote_skew: assert property (p_remote_skew) else $error("remote value late on pin");

  sequence s_no_edge;
    !bc_frame && !link_rise;
  endsequence

  property p_ack_answer;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && (REG_REQ.wr || REG_REQ.rd) |=> REG_ACK;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no acknowledge");

  property p_refused_count;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      CE && (fwd_count == 3'h0 || fwd_count > 3'h4) |=> !FWD_STB;
  endproperty
  a_refused_count: assert property (p_refused_count) else $error("bad count sent");

  property p_no_false_frame;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      $rose(RESET_N) |-> s_no_edge ##1 s_no_edge ##1 s_no_edge;
  endproperty
  a_no_false_frame: assert property (p_no_false_frame) else $error("edge after reset");
endmodule

//--- rtl/link_pin_pkg.sv
/*
  Shared constants and carriers of the serializer link pin block.
  Assumes a 10 MHz system clock; all users refer to names as link_pin_pkg::name.
*/
package link_pin_pkg;
  // Register offsets
  localparam logic [7:0] OFS_REMOTE_SEL   = 8'h0d;
  localparam logic [7:0] OFS_DIR_CTRL     = 8'h0e;
  localparam logic [7:0] OFS_FWD_CFG      = 8'h33;
  localparam logic [7:0] OFS_LEVEL_STS    = 8'h53;
  // Values after reset: all pins inputs, nothing driven, nothing forwarded
  localparam logic [7:0] RST_REMOTE_SEL   = 8'h00;
  localparam logic [7:0] RST_DIR_CTRL     = 8'h0f;
  localparam logic [7:0] RST_FWD_CFG      = 8'h00;
  // Field positions
  localparam int IN_EN_LSB     = 0;
  localparam int DRV_EN_LSB    = 4;
  localparam int LOCAL_LSB     = 0;
  localparam int REMOTE_EN_LSB = 4;
  localparam int CNT_LSB       = 0;
  localparam int SENSE_LSB     = 4;
  // Forward sampling periods in frames
  localparam logic [2:0] PERIOD_ONE   = 3'h1;
  localparam logic [2:0] PERIOD_TWO   = 3'h2;
  localparam logic [2:0] PERIOD_MANY  = 3'h5;
  // Frame sizes in bits
  localparam int FWD_FRAME_BITS = 40;
  localparam int BC_FRAME_BITS  = 30;
  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int FWD_LATENCY_NS   = 225;
  localparam int BC_SKEW_NS       = 600;
  localparam int FWD_LATENCY_CYC  = (FWD_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                    (FWD_LATENCY_NS / CLK_PERIOD_NS);
  localparam int BC_SKEW_CYC      = (BC_SKEW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                    (BC_SKEW_NS / CLK_PERIOD_NS);
  // Remote sampling rates per clocking mode, in kHz times ten
  localparam int BC_RATE_SYNC_KHZ10  = 16700;
  localparam int BC_RATE_NSYNC_KHZ10 = 3340;
  localparam int BC_RATE_DVP_KHZ10   = 835;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] pins;
    logic [2:0] count;
  } fwd_sample_s;
endpackage

//--- sim/link_far_model.sv
/*
  Far side of the link: forward frame marker and back-channel frames.
  Assumes the bench calls send_bc by hierarchical name, frames >= 4 cycles apart.
*/
`timescale 1ns/100ps
module link_far_model (
  // Control from bench
  input  wire logic       run,
  // Link signals
  output      logic       link_clk,
  output      logic [3:0] bc_val,
  output      logic       bc_tgl
);
  initial begin
    link_clk = 1'b0;
    bc_val   = 4'h0;
    bc_tgl   = 1'b0;
  end

  // Frame marker, 800 ns period, still while forwarding is off
  always begin
    #400;
    link_clk = run ? ~link_clk : 1'b0;
  end

  // One back frame; value withdrawn once the hold runs out
  task automatic send_bc(input logic [3:0] v);
    bc_val = v;
    bc_tgl = ~bc_tgl;
    #700;
    bc_val = ~v;
  endtask
endmodule

//--- sim/serializer_link_gpio_test.sv
/*
  Self-checking bench of the link pin block against a register model.
  Assumes the package and the far-side model are compiled first.
*/
`timescale 1ns/100ps
module serializer_link_gpio_test;
  logic                      clk_sys = 1'b0;
  logic                      reset_n = 1'b0;
  logic                      run     = 1'b0;
  logic                      ce      = 1'b1;
  link_pin_pkg::reg_req_s    req     = '0;
  link_pin_pkg::fwd_sample_s fwd_sample;
  logic [7:0]                rdata;
  logic                      reg_ack;
  logic                      fwd_stb;
  logic                      link_clk;
  logic                      bc_tgl;
  logic [3:0]                pin_in  = 4'h0;
  logic [3:0]                pin_out;
  logic [3:0]                pin_oe;
  logic [3:0]                pin_pd;
  logic [3:0]                bc_val;
  logic [3:0]                rv      = 4'h0;
  logic [1:0]                vsense;
  logic [7:0]                cfgs [3] = '{8'h0f, 8'hff, 8'hf0};
  int                        error_cnt = 0;
  int                        n_tests   = 0;
  int                        cyc       = 0;
  int                        mdl [int];

  serializer_link_gpio DUT (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce),
    .REG_REQ(req), .REG_RDATA(rdata), .REG_ACK(reg_ack),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLDOWN(pin_pd), .VSENSE_EN(vsense),
    .LINK_CLK(link_clk), .FWD_SAMPLE(fwd_sample), .FWD_STB(fwd_stb),
    .BC_PIN_VAL(bc_val), .BC_FRAME_TGL(bc_tgl)
  );

  link_far_model far (.run(run), .link_clk(link_clk), .bc_val(bc_val), .bc_tgl(bc_tgl));

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc++;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle strobe; answer taken in the cycle after
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] exp;
    exp = (a == 8'h53) ? {4'h0, pin_in & mdl[14][3:0]} : (mdl.exists(a) ? mdl[a][7:0] : 8'h0);
    @(negedge clk_sys);
    req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clk_sys);
    req = '0;
    chk("ack", 8'h1, {7'h0, reg_ack});
    if (w && mdl.exists(a)) mdl[a] = d;
    if (!w) chk("rdata", exp, rdata);
  endtask

  task automatic pins_check;
    logic [3:0] sel;
    sel = mdl[13][7:4];
    repeat (2) @(negedge clk_sys);
    chk("oe", {4'h0, mdl[14][7:4]}, {4'h0, pin_oe});
    chk("pulldown", {4'h0, mdl[14][3:0]}, {4'h0, pin_pd});
    chk("vsense", {6'h0, mdl[51][5:4]}, {6'h0, vsense});
    chk("out", {4'h0, (rv & sel) | (mdl[13][3:0] & ~sel)}, {4'h0, pin_out});
  endtask

  // Pins held still while forwarded, far below the sampling rate
  task automatic fwd_check(input int c);
    int t0;
    int per;
    int ns;
    per = (c == 1) ? 1 : (c == 2) ? 2 : 5;
    t0 = -1;
    ns = 0;
    reg_op(1'b1, 8'h33, c[7:0]);
    run = 1'b1;
    repeat (100) begin
      @(negedge clk_sys);
      if (fwd_stb === 1'b1) begin
        if (c == 0 || c > 4) chk("stb", 8'h0, 8'h1);
        else begin
          chk("pins", {4'h0, pin_in & 4'((1 << c) - 1)}, {4'h0, fwd_sample.pins});
          chk("count", c[7:0], {5'h0, fwd_sample.count});
          if (t0 >= 0) chk("gap", 8'(8 * per), 8'(cyc - t0));
          t0 = cyc;
          ns++;
        end
      end
    end
    if (c > 0 && c < 5) chk("strobes", 8'h1, {7'h0, ns >= 2});
    run = 1'b0;
  endtask

  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #1_000_000;
    error_cnt++;
    final_report;
  end

  initial begin
    mdl[13] = 0;
    mdl[14] = 15;
    mdl[51] = 0;
    void'($urandom(32'h663612a2));
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    foreach (mdl[a]) reg_op(1'b0, a[7:0], 8'h0);
    pins_check;
    // Enable low: a held write must neither land nor be answered
    ce = 1'b0;
    req = '{addr: 8'h0d, wdata: 8'hff, wr: 1'b1, rd: 1'b0};
    repeat (3) @(negedge clk_sys);
    chk("ce_ack", 8'h0, {7'h0, reg_ack});
    req = '0;
    ce = 1'b1;
    reg_op(1'b0, 8'h0d, 8'h0);
    // Inputs only, both enables, outputs only, then anything
    for (int i = 0; i < 4; i++) begin
      reg_op(1'b1, 8'h0e, i < 3 ? cfgs[i] : 8'($urandom));
      pin_in = 4'($urandom);
      repeat (4) @(negedge clk_sys);
      reg_op(1'b0, 8'h53, 8'h0);
      pins_check;
    end
    reg_op(1'b1, 8'h53, 8'($urandom));
    reg_op(1'b0, 8'h53, 8'h0);
    reg_op(1'b0, 8'h40, 8'h0);
    reg_op(1'b1, 8'h0d, {4'h0, 4'($urandom)});
    pins_check;
    reg_op(1'b1, 8'h0d, 8'($urandom));
    rv = 4'($urandom);
    far.send_bc(rv);
    pins_check;
    reg_op(1'b1, 8'h33, 8'h30);
    pins_check;
    pin_in = 4'($urandom);
    for (int c = 0; c < 6; c++) fwd_check(c);
    // Reset in mid-run with the back frame toggle left high
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    mdl[13] = 0;
    mdl[14] = 15;
    mdl[51] = 0;
    rv = 4'h0;
    foreach (mdl[a]) reg_op(1'b0, a[7:0], 8'h0);
    pins_check;
    final_report;
  end
endmodule
